// ### hw/user_glyph_ram_lookup.sv
// User glyph pattern memory with host access and display row lookup.
// Assumes host commands and display requests are synchronous to clk_sys_i.
`timescale 1ns/10ps
`include "glyph_cfg.svh"

module user_glyph_ram_lookup #(
  parameter int ADDR_W = `GLYPH_ADDR_W,
  parameter int DATA_W = `GLYPH_DATA_W,
  parameter int DEPTH  = `GLYPH_DEPTH
) (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  // Mode levels
  input  wire logic                   font_5x10_i,
  input  wire logic                   addr_up_i,
  // Host access
  input  wire glyph_pkg::host_cmd_s   host_cmd_i,
  output logic [DATA_W-1:0]           rd_data_o,
  output logic                        rd_valid_o,
  output logic [ADDR_W-1:0]           addr_o,
  // Display lookup
  input  wire glyph_pkg::glyph_req_s  req_i,
  output glyph_pkg::glyph_pix_s       pix_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and address counter
  ////////////////////////////////////////////////////////////////////////////

  logic [DATA_W-1:0] glyph_mem [DEPTH]; // Pattern rows, eight per 5x8 glyph
  logic [ADDR_W-1:0] host_addr;         // Current counter address
  logic              host_step;         // Access done, move the counter

  // A write or read without a load in the same cycle moves the counter
  assign host_step = host_cmd_i.wr | host_cmd_i.rd;

  // Counter shared by writes and reads
  glyph_addr_counter #(
    .ADDR_W      (ADDR_W)
  ) u_addr_counter (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .load_i      (host_cmd_i.set_addr),
    .load_addr_i (host_cmd_i.addr),
    .step_i      (host_step),
    .up_i        (addr_up_i),
    .addr_o      (host_addr)
  );

  assign addr_o = host_addr;

  // Host writes land at once, display keeps running
  always_ff @(posedge clk_sys_i) begin
    if (host_cmd_i.wr) begin
      glyph_mem[host_addr] <= host_cmd_i.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host read path
  ////////////////////////////////////////////////////////////////////////////

  logic [DATA_W-1:0] rd_data_q; // Captured row word
  logic              rd_valid_q; // Read answer present

  // Capture the word at the counter before it steps
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= host_cmd_i.rd;
      if (host_cmd_i.rd) begin
        rd_data_q <= glyph_mem[host_addr];
      end
    end
  end

  assign rd_data_o  = rd_data_q;
  assign rd_valid_o = rd_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Display address forming
  ////////////////////////////////////////////////////////////////////////////

  logic              user_bank;   // Code selects the pattern memory
  logic [ADDR_W-1:0] disp_addr;   // Pattern memory address for this row
  logic              cursor_row;  // Row is the cursor line of the glyph
  logic [DATA_W-1:0] disp_word;   // Stored row word

  // Only codes with a clear upper nibble use the pattern memory
  assign user_bank = (req_i.code[`CODE_BANK_HI:`CODE_BANK_LO] == `BANK_USER);

  // Slot and row bits go into the address, per font
  always_comb begin
    if (font_5x10_i) begin
      // Four slots from code bits 1-2, sixteen row places each
      disp_addr  = {req_i.code[`CODE_SLOT10_HI:`CODE_SLOT10_LO],
                    req_i.row[`ROW10_HI:0]};
      cursor_row = (req_i.row == `CURSOR_ROW10);
    end else begin
      // Eight slots from code bits 0-2, code bit 3 dropped
      // The same drop makes each code pair alias
      // Row number fills the low address bits
      disp_addr  = {req_i.code[`CODE_SLOT8_HI:`CODE_SLOT8_LO],
                    req_i.row[`ROW8_HI:0]};
      cursor_row = (req_i.row == `CURSOR_ROW8);
    end
  end

  assign disp_word = glyph_mem[disp_addr];

  ////////////////////////////////////////////////////////////////////////////
  // Pixel forming and output register
  ////////////////////////////////////////////////////////////////////////////

  logic [`GLYPH_PIX_W-1:0] pix_d;  // Pixels before the output register
  glyph_pkg::glyph_pix_s   pix_q;  // Registered result

  // Ones light pixels, upper row bits dropped, cursor ORed on its row
  always_comb begin
    pix_d = '0;
    if (user_bank) begin
      // Bit 4 stays the leftmost column
      // A stored one lights, a zero stays dark
      // Bits 5-7 are not taken
      pix_d = disp_word[`PIX_HI:`PIX_LO];
      if (cursor_row) begin
        // Stored ones light with or without the cursor
        // The host is expected to keep this row clear
        pix_d = pix_d | req_i.cursor;
      end
    end
  end

  // Result register; built-in codes leave the pixels to the font table
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pix_q <= '0;
    end else begin
      pix_q.valid   <= req_i.valid;
      pix_q.builtin <= ~user_bank;
      pix_q.code    <= req_i.code;
      pix_q.row     <= req_i.row;
      pix_q.pixels  <= pix_d;
    end
  end

  assign pix_o = pix_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Helper: request for a user glyph on a 5x8 font
  logic user8_req;
  assign user8_req = req_i.valid & user_bank & ~font_5x10_i;

  // Helper: word at the counter, which a read hands back one cycle later
  logic [DATA_W-1:0] host_word;
  assign host_word = glyph_mem[host_addr];

  // Named steps of a host access and of a cursor-row lookup
  sequence s_host_write;
    host_cmd_i.wr && !host_cmd_i.rd && !host_cmd_i.set_addr;
  endsequence

  sequence s_host_read;
    host_cmd_i.rd && !host_cmd_i.wr && !host_cmd_i.set_addr;
  endsequence

  sequence s_user8_cursor;
    user8_req && req_i.row == `CURSOR_ROW8;
  endsequence

  AST_BUILTIN_ROUTE:
  assert property (req_i.valid && !user_bank |=> pix_o.builtin && pix_o.pixels == '0)
    else $error("Built-in code did not route to the font table");

  AST_USER_ROUTE:
  assert property (req_i.valid && user_bank |=> pix_o.valid && !pix_o.builtin)
    else $error("User code did not use the pattern memory");

  AST_UP_STEP:
  assert property (s_host_write and addr_up_i |=> addr_o == ADDR_W'($past(addr_o) + 1'b1))
    else $error("Counter did not step up after a write");

  AST_DOWN_STEP:
  assert property (s_host_read and !addr_up_i |=> addr_o == ADDR_W'($past(addr_o) - 1'b1))
    else $error("Counter did not step down after a read");

  // A write lands at the address that the counter held when it was taken
  AST_WRITE_LANDS:
  assert property (s_host_write |=> glyph_mem[$past(host_addr)] == $past(host_cmd_i.data))
    else $error("Written row did not land in the pattern memory");

  // A read answers one cycle later with the word at the old counter address
  AST_READ_ANSWER:
  assert property (s_host_read |=> rd_valid_o && rd_data_o == $past(host_word))
    else $error("Read answer missing or wrong");

  AST_CURSOR_OR:
  assert property (s_user8_cursor
                   |=> (pix_o.pixels & $past(req_i.cursor)) == $past(req_i.cursor))
    else $error("Cursor pattern missing on cursor row");

  AST_STORED_CURSOR_ROW:
  assert property (s_user8_cursor
                   |=> (pix_o.pixels & $past(disp_word[`PIX_HI:`PIX_LO]))
                       == $past(disp_word[`PIX_HI:`PIX_LO]))
    else $error("Stored cursor row bit not lit");

  AST_PLAIN_ROW:
  assert property (user8_req && req_i.row != `CURSOR_ROW8 && !host_cmd_i.wr
                   |=> pix_o.pixels == $past(disp_word[`PIX_HI:`PIX_LO]))
    else $error("Pixels differ from the stored row");

  AST_BIT3_ALIAS:
  assert property (user8_req && !host_cmd_i.wr ##1 req_i.valid && !host_cmd_i.wr
                   && req_i.code == ($past(req_i.code) ^ 8'h08)
                   && req_i.row == $past(req_i.row) && req_i.row != `CURSOR_ROW8
                   && !font_5x10_i
                   |=> pix_o.pixels == $past(pix_o.pixels))
    else $error("Codes differing in bit 3 gave different glyphs");

endmodule

// ### hw/glyph_cfg.svh
// Constants for the user glyph pattern memory and its display lookup.
// Assumes one clock domain; included by the package and by every design file.
`ifndef GLYPH_CFG_SVH
`define GLYPH_CFG_SVH

// Widths of the pattern memory and of the display path
`define GLYPH_ADDR_W    6
`define GLYPH_DATA_W    8
`define GLYPH_DEPTH     64
`define CHAR_CODE_W     8
`define GLYPH_ROW_W     4
`define GLYPH_PIX_W     5

// Field positions inside a character code
`define CODE_BANK_HI    7
`define CODE_BANK_LO    4
`define CODE_SLOT8_HI   2
`define CODE_SLOT8_LO   0
`define CODE_SLOT10_HI  2
`define CODE_SLOT10_LO  1

// Row fields and cursor rows for each font
`define ROW8_HI         2
`define ROW10_HI        3
`define CURSOR_ROW8     4'h7
`define CURSOR_ROW10    4'ha

// Pixel field of a stored row word, bit 4 is the leftmost column
`define PIX_HI          4
`define PIX_LO          0

// Counter reset value and user bank code
`define ADDR_RST        6'h00
`define BANK_USER       4'h0

`endif

// ### hw/glyph_pkg.sv
// Types shared by the glyph memory lookup, the host model and the bench.
// Assumes glyph_cfg.svh is on the include path.
`include "glyph_cfg.svh"

package glyph_pkg;

  // One host access to the pattern memory
  typedef struct packed {
    logic                        set_addr; // Load the address counter
    logic                        wr;       // Write data at the counter
    logic                        rd;       // Read data at the counter
    logic [`GLYPH_ADDR_W-1:0]    addr;     // Address to load
    logic [`GLYPH_DATA_W-1:0]    data;     // Row word to write
  } host_cmd_s;

  // One display lookup request
  typedef struct packed {
    logic                        valid;    // Request present
    logic [`CHAR_CODE_W-1:0]     code;     // Character code from text memory
    logic [`GLYPH_ROW_W-1:0]     row;      // Row within the glyph
    logic [`GLYPH_PIX_W-1:0]     cursor;   // Cursor pattern at this position
  } glyph_req_s;

  // One display lookup result
  typedef struct packed {
    logic                        valid;    // Result present
    logic                        builtin;  // Code belongs to built-in font
    logic [`CHAR_CODE_W-1:0]     code;     // Code passed on for the font table
    logic [`GLYPH_ROW_W-1:0]     row;      // Row passed on for the font table
    logic [`GLYPH_PIX_W-1:0]     pixels;   // Lit pixels, bit 4 leftmost
  } glyph_pix_s;

endpackage

// ### hw/glyph_addr_counter.sv
// Address counter for host accesses to the user glyph memory.
// Assumes a single clock; load and step come from the host command decode.
`timescale 1ns/10ps
`include "glyph_cfg.svh"

module glyph_addr_counter #(
  parameter int ADDR_W = `GLYPH_ADDR_W
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Control
  input  wire logic              load_i,
  input  wire logic [ADDR_W-1:0] load_addr_i,
  input  wire logic              step_i,
  input  wire logic              up_i,
  // Current address
  output logic      [ADDR_W-1:0] addr_o
);

  logic [ADDR_W-1:0] addr_q; // Counter value
  logic [ADDR_W-1:0] addr_d; // Next counter value

  // Load wins over a step; a step moves one place and wraps
  always_comb begin
    addr_d = addr_q;
    if (load_i) begin
      addr_d = load_addr_i;
    end else if (step_i) begin
      // Step by one in the chosen direction
      addr_d = up_i ? ADDR_W'(addr_q + 1'b1) : ADDR_W'(addr_q - 1'b1);
    end
  end

  // Counter register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= `ADDR_RST;
    end else begin
      addr_q <= addr_d;
    end
  end

  assign addr_o = addr_q;

endmodule

// ### test/glyph_host_model.sv
// Host processor model that writes and reads rows of the user glyph memory.
// Assumes the bench calls its tasks and the block answers on the next cycle.
`timescale 1ns/10ps

module glyph_host_model (
  // Clock
  input  wire logic            clk_sys_i,
  // Answers from the block
  input  wire logic [7:0]      rd_data_i,
  input  wire logic            rd_valid_i,
  // Host command
  output glyph_pkg::host_cmd_s host_cmd_o
);
  // Quiet bus at time zero
  initial host_cmd_o = '0;

  // One command for one cycle; afterwards the lines no longer hold the value
  task automatic send(input logic s, input logic w, input logic r,
                      input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    host_cmd_o = '{set_addr: s, wr: w, rd: r, addr: a, data: d};
    @(negedge clk_sys_i);
    host_cmd_o = '{set_addr: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask

  // Load the address counter
  task automatic set_addr(input logic [5:0] a);
    send(1'b1, 1'b0, 1'b0, a, 8'h00);
  endtask

  // Write a row; the cursor row is kept blank unless ink is asked for
  task automatic put(input logic [5:0] a, input logic [7:0] d, input logic ink);
    if (a[2:0] == 3'h7 && !ink) begin
      d[4:0] = 5'h00;
    end
    send(1'b0, 1'b1, 1'b0, 6'h00, d);
  endtask

  // Read a row; the answer is taken one cycle after the request
  task automatic get(output logic [7:0] d, output logic v);
    send(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
    d = rd_data_i;
    v = rd_valid_i;
  endtask
endmodule

// ### test/user_glyph_ram_lookup_tb.sv
// Self-checking bench for the user glyph memory and its display lookup.
// Assumes the host model sits on the host port; the bench drives lookups.
`timescale 1ns/10ps

module user_glyph_ram_lookup_tb;
  logic                  clk_sys_i = 1'b0; // System clock
  logic                  rst_i     = 1'b1; // Reset
  logic                  font_5x10_i = 1'b0; // Font select
  logic                  addr_up_i   = 1'b1; // Counter direction
  glyph_pkg::host_cmd_s  host_cmd;          // From host model
  glyph_pkg::glyph_req_s req_i = '0;        // Lookup request
  glyph_pkg::glyph_pix_s pix_o;             // Lookup result
  logic [7:0]            rd_data_o;         // Read word
  logic                  rd_valid_o;        // Read strobe
  logic [5:0]            addr_o;            // Counter
  logic [7:0]            exp_mem [64];      // Expected memory
  int                    fail_count = 0;    // Mismatches
  int                    n_checks   = 0;    // Comparisons

  // 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;

  user_glyph_ram_lookup u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .font_5x10_i(font_5x10_i),
    .addr_up_i(addr_up_i), .host_cmd_i(host_cmd), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .addr_o(addr_o), .req_i(req_i), .pix_o(pix_o));

  glyph_host_model u_host (
    .clk_sys_i(clk_sys_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .host_cmd_o(host_cmd));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Row pattern: top bits set, blank cursor row as a careful host keeps it
  function automatic logic [7:0] pat(input logic [5:0] a);
    pat = {3'h7, a[4:0] ^ {a[5], a[5:2]}};
    if (a[2:0] == 3'h7) pat[4:0] = 5'h00;
  endfunction

  // One lookup, judged one cycle later
  task automatic look(input logic [7:0] c, input logic [3:0] r, input logic [4:0] cur,
                      input logic [4:0] px, input logic bi);
    @(negedge clk_sys_i);
    req_i = '{valid: 1'b1, code: c, row: r, cursor: cur};
    @(negedge clk_sys_i);
    req_i = '{valid: 1'b0, code: ~c, row: ~r, cursor: ~cur};
    chk("pix_valid", {7'h00, pix_o.valid}, 8'h01);
    chk("builtin", {7'h00, pix_o.builtin}, {7'h00, bi});
    chk("pixels", {3'h0, pix_o.pixels}, {3'h0, px});
    chk("code_fwd", pix_o.code, c);
    chk("row_fwd", {4'h0, pix_o.row}, {4'h0, r});
  endtask

  // Back-to-back lookups of a code pair that differs only in bit 3
  task automatic t_alias();
    @(negedge clk_sys_i);
    req_i = '{valid: 1'b1, code: 8'h05, row: 4'h3, cursor: 5'h1f};
    @(negedge clk_sys_i);
    req_i = '{valid: 1'b1, code: 8'h0d, row: 4'h3, cursor: 5'h1f};
    chk("alias_a", {3'h0, pix_o.pixels}, {3'h0, exp_mem[6'h2b][4:0]});
    @(negedge clk_sys_i);
    req_i = '{valid: 1'b0, code: 8'hf2, row: 4'hc, cursor: 5'h00};
    chk("alias_b", {3'h0, pix_o.pixels}, {3'h0, exp_mem[6'h2b][4:0]});
    chk("alias_valid", {7'h00, pix_o.valid}, 8'h01);
    $display("test alias done");
  endtask

  // Reset in mid-run clears the counter, the read outputs and the result pixels
  task automatic t_reset();
    logic [7:0] d;
    logic       v;
    u_host.set_addr(6'h2a);
    u_host.get(d, v);
    chk("rd_before_rst", d, exp_mem[6'h2a]);
    rst_i = 1'b1;
    @(negedge clk_sys_i);
    chk("addr_mid_rst", {2'h0, addr_o}, 8'h00);
    chk("rd_mid_rst", rd_data_o, 8'h00);
    chk("rdv_mid_rst", {7'h00, rd_valid_o}, 8'h00);
    chk("pix_mid_rst", {3'h0, pix_o.pixels}, 8'h00);
    rst_i = 1'b0;
    look(8'h01, 4'h0, 5'h00, exp_mem[6'h08][4:0], 1'b0);
    $display("test mid-run reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Fill all 64 rows upward, counter wraps
  task automatic t_fill();
    u_host.set_addr(6'h00);
    for (int i = 0; i < 64; i++) begin
      exp_mem[i] = pat(6'(i));
      u_host.put(6'(i), pat(6'(i)), 1'b0);
      chk("addr_up", {2'h0, addr_o}, {2'h0, 6'(i + 1)});
    end
    $display("test fill done");
  endtask

  // Read back stepping down
  task automatic t_read();
    logic [7:0] d;
    logic       v;
    addr_up_i = 1'b0;
    u_host.set_addr(6'h0d);
    for (int i = 0; i < 2; i++) begin
      u_host.get(d, v);
      chk("rd_valid", {7'h00, v}, 8'h01);
      chk("rd_data", d, exp_mem[13 - i]);
      chk("addr_dn", {2'h0, addr_o}, {2'h0, 6'(12 - i)});
    end
    $display("test read done");
  endtask

  // Every user code and row in the 8-row font, cursor on the last row
  task automatic t_small();
    logic [5:0] a;
    for (int c = 0; c < 16; c++) begin
      for (int r = 0; r < 8; r++) begin
        a = {3'(c), 3'(r)};
        look(8'(c), 4'(r), 5'h15, exp_mem[a][4:0] | (r == 7 ? 5'h15 : 5'h00), 1'b0);
      end
    end
    $display("test small font done");
  endtask

  // Codes with upper bits set go to the built-in font
  task automatic t_builtin();
    look(8'h10, 4'h2, 5'h1f, 5'h00, 1'b1);
    look(8'h80, 4'h7, 5'h1f, 5'h00, 1'b1);
    look(8'hff, 4'h0, 5'h00, 5'h00, 1'b1);
    $display("test builtin done");
  endtask

  // Ink stored in the cursor row lights with or without the cursor
  task automatic t_ink();
    addr_up_i = 1'b1;
    u_host.set_addr(6'h17);
    u_host.put(6'h17, 8'h11, 1'b1);
    exp_mem[6'h17] = 8'h11;
    look(8'h0a, 4'h7, 5'h00, 5'h11, 1'b0);
    look(8'h02, 4'h7, 5'h04, 5'h15, 1'b0);
    $display("test ink done");
  endtask

  // Tall font: four glyphs, code bits 0 and 3 ignored, cursor on row 10
  task automatic t_tall();
    font_5x10_i = 1'b1;
    look(8'h03, 4'ha, 5'h01, exp_mem[6'h1a][4:0] | 5'h01, 1'b0);
    look(8'h0c, 4'h3, 5'h1f, exp_mem[6'h23][4:0], 1'b0);
    font_5x10_i = 1'b0;
    $display("test tall font done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Counts, verdict and stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk("addr_rst", {2'h0, addr_o}, 8'h00);
    chk("pix_rst", {7'h00, pix_o.valid}, 8'h00);
    t_fill();
    t_read();
    t_small();
    t_alias();
    t_builtin();
    t_ink();
    t_tall();
    t_reset();
    end_of_test();
  end

  // Watchdog, about fourteen times the expected run
  initial begin
    #60000;
    fail_count++;
    end_of_test();
  end
endmodule
